// ---- odsg_pkg.sv ----
package odsg_pkg;
  // widths of the measurement path
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned LEN_W = 32;
  localparam int unsigned PCT_W = 7;
  // threshold limits and default in percent
  localparam logic [6:0] THRESH_DEFAULT = 7'h0F;
  localparam logic [6:0] THRESH_MAX = 7'h64;
  // reaction limit on either object edge
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned REACT_US = 1000;
  localparam int unsigned REACT_CYC = REACT_US * CLK_MHZ;
  // debounce filter applied to the presence compare
  localparam int unsigned FILT_CYC = 16;
  localparam logic [SPEED_W-1:0] SPEED_ZERO = 16'h0000;
  localparam logic [LEN_W-1:0] LEN_ZERO = 32'h0000_0000;
endpackage : odsg_pkg

// ---- odsg_presence_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// carries the filtered presence verdict between the modules
interface odsg_presence_if;
  logic present;
  logic arrive;
  modport src (output present, output arrive);
  modport dst (input present, input arrive);
endinterface : odsg_presence_if
`default_nettype wire

// ---- odsg_presence.sv ----
`timescale 1ns/1ps
`default_nettype none
// compares dc level to threshold and filters the result
module odsg_presence #(
  parameter int unsigned FILT = odsg_pkg::FILT_CYC
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [odsg_pkg::PCT_W-1:0] dc_level_in,
  input wire logic [odsg_pkg::PCT_W-1:0] thresh_in,
  odsg_presence_if.src pres
);
  logic raw;
  logic present;
  logic arrive;
  logic [4:0] cnt;
  logic next_present;
  logic next_arrive;
  logic [4:0] next_cnt;

  // strict greater-than: equal level counts as absent
  assign raw = (dc_level_in > thresh_in);

  // short filter keeps edges well inside the reaction limit
  always_comb begin
    next_present = present;
    next_arrive = 1'b0;
    next_cnt = 5'h00;
    if (raw != present) begin
      next_cnt = cnt + 5'h01;
      if (cnt >= 5'(FILT - 1)) begin
        next_present = raw;
        next_arrive = raw;
        next_cnt = 5'h00;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      present <= 1'b0;
      arrive <= 1'b0;
      cnt <= 5'h00;
    end else begin
      present <= next_present;
      arrive <= next_arrive;
      cnt <= next_cnt;
    end
  end

  assign pres.present = present;
  assign pres.arrive = arrive;
endmodule : odsg_presence
`default_nettype wire

// ---- odsg_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module odsg_gate #(
  parameter int unsigned SW = odsg_pkg::SPEED_W,
  parameter int unsigned LW = odsg_pkg::LEN_W,
  parameter int unsigned HOLD_W = 32
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic detect_mode_in,
  input wire logic clear_on_new_in,
  input wire logic factory_restore_in,
  input wire logic thresh_wr_in,
  input wire logic [odsg_pkg::PCT_W-1:0] thresh_data_in,
  input wire logic [odsg_pkg::PCT_W-1:0] dc_level_in,
  input wire logic [SW-1:0] speed_in,
  input wire logic speed_valid_in,
  input wire logic len_tick_in,
  input wire logic length_reset_in,
  input wire logic [HOLD_W-1:0] hold_cycles_in,
  output logic [SW-1:0] speed_out,
  output logic [LW-1:0] length_out,
  output logic present_out,
  output logic holding_out,
  output logic [odsg_pkg::PCT_W-1:0] thresh_out
);
  typedef enum logic [1:0] {
    ODSG_LIVE = 2'b00,
    ODSG_HOLD = 2'b01,
    ODSG_LOST = 2'b11
  } odsg_state_t;

  odsg_presence_if pres_if ();

  logic [odsg_pkg::PCT_W-1:0] thresh;
  logic [odsg_pkg::PCT_W-1:0] next_thresh;
  odsg_state_t state;
  odsg_state_t next_state;
  logic [SW-1:0] held;
  logic [SW-1:0] next_held;
  logic [HOLD_W-1:0] hold_cnt;
  logic [HOLD_W-1:0] next_hold_cnt;
  logic [SW-1:0] speed;
  logic [SW-1:0] next_speed;
  logic [LW-1:0] length;
  logic [LW-1:0] next_length;
  logic gate_open;
  logic accum;

  odsg_presence u_presence (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .dc_level_in(dc_level_in),
    .thresh_in(thresh),
    .pres(pres_if.src)
  );

  // threshold store; writes above full scale are clamped
  always_comb begin
    next_thresh = thresh;
    if (factory_restore_in) begin
      next_thresh = odsg_pkg::THRESH_DEFAULT;
    end else if (thresh_wr_in) begin
      if (thresh_data_in > odsg_pkg::THRESH_MAX) begin
        next_thresh = odsg_pkg::THRESH_MAX;
      end else begin
        next_thresh = thresh_data_in;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      thresh <= odsg_pkg::THRESH_DEFAULT;
    end else begin
      thresh <= next_thresh;
    end
  end

  // outside detection mode the gate is always open
  assign gate_open = !detect_mode_in || pres_if.present;

  // hold machine: only armed while the gate is open
  always_comb begin
    next_state = state;
    next_held = held;
    next_hold_cnt = hold_cnt;
    case (state)
      ODSG_LIVE: begin
        if (speed_valid_in) begin
          next_held = speed_in;
        end else if (gate_open) begin
          next_state = ODSG_HOLD;
          next_hold_cnt = hold_cycles_in;
        end
      end
      ODSG_HOLD: begin
        if (speed_valid_in) begin
          next_state = ODSG_LIVE;
          next_held = speed_in;
        end else if (!gate_open) begin
          next_state = ODSG_LIVE;
        end else if (hold_cnt == '0) begin
          next_state = ODSG_LOST;
        end else begin
          next_hold_cnt = hold_cnt - 1'b1;
        end
      end
      ODSG_LOST: begin
        if (speed_valid_in || !gate_open) begin
          next_state = ODSG_LIVE;
          next_held = speed_valid_in ? speed_in : held;
        end
      end
      default: begin
        next_state = ODSG_LIVE;
      end
    endcase
    if (!gate_open) begin
      next_hold_cnt = '0;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ODSG_LIVE;
      held <= odsg_pkg::SPEED_ZERO;
      hold_cnt <= '0;
    end else begin
      state <= next_state;
      held <= next_held;
      hold_cnt <= next_hold_cnt;
    end
  end

  // reported speed; zero when gated off or hold has lapsed
  always_comb begin
    next_speed = odsg_pkg::SPEED_ZERO;
    if (!gate_open) begin
      next_speed = odsg_pkg::SPEED_ZERO;
    end else if (speed_valid_in) begin
      next_speed = speed_in;
    end else if (state == ODSG_HOLD || state == ODSG_LIVE) begin
      next_speed = held;
    end else begin
      next_speed = odsg_pkg::SPEED_ZERO;
    end
  end

  // length grows only when a nonzero speed is being reported
  assign accum = gate_open && len_tick_in && (speed != odsg_pkg::SPEED_ZERO);

  // new-object clear beats the tick in the same cycle
  always_comb begin
    next_length = length;
    if (length_reset_in) begin
      next_length = odsg_pkg::LEN_ZERO;
    end else if (detect_mode_in && clear_on_new_in && pres_if.arrive) begin
      next_length = odsg_pkg::LEN_ZERO;
    end else if (accum) begin
      next_length = length + LW'(1);
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      speed <= odsg_pkg::SPEED_ZERO;
      length <= odsg_pkg::LEN_ZERO;
      present_out <= 1'b0;
      holding_out <= 1'b0;
      thresh_out <= odsg_pkg::THRESH_DEFAULT;
    end else begin
      speed <= next_speed;
      length <= next_length;
      present_out <= pres_if.present;
      holding_out <= (next_state == ODSG_HOLD);
      thresh_out <= next_thresh;
    end
  end

  assign speed_out = speed;
  assign length_out = length;
endmodule : odsg_gate
`default_nettype wire

// ---- odsg_gate_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module odsg_gate_asserts (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic detect_mode_in,
  input wire logic clear_on_new_in,
  input wire logic factory_restore_in,
  input wire logic [6:0] dc_level_in,
  input wire logic speed_valid_in,
  input wire logic length_reset_in,
  input wire logic [15:0] speed_out,
  input wire logic [31:0] length_out,
  input wire logic present_out,
  input wire logic holding_out,
  input wire logic [6:0] thresh_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  logic [4:0] n_hi, n_lo, next_n_hi, next_n_lo;
  logic above;
  // run lengths of the raw compare; saturate so long runs stay valid
  always_comb begin
    above = dc_level_in > thresh_out;
    next_n_hi = !above ? 5'h00 : (n_hi == 5'h1F) ? n_hi : n_hi + 5'h01;
    next_n_lo = above ? 5'h00 : (n_lo == 5'h1F) ? n_lo : n_lo + 5'h01;
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      n_hi <= 5'h00;
      n_lo <= 5'h00;
    end else begin
      n_hi <= next_n_hi;
      n_lo <= next_n_lo;
    end
  end
  property p_pres_on; n_hi >= 5'h12 |-> present_out; endproperty
  a_pres_on: assert property (p_pres_on) else $error("no presence");
  property p_pres_off; n_lo >= 5'h12 |-> !present_out; endproperty
  a_pres_off: assert property (p_pres_off) else $error("presence");
  property p_restore; factory_restore_in |=> thresh_out == 7'h0F; endproperty
  a_restore: assert property (p_restore) else $error("restore");
  property p_max; thresh_out <= 7'h64; endproperty
  a_max: assert property (p_max) else $error("threshold range");
  sequence s_absent;
    detect_mode_in && $past(detect_mode_in) && !present_out
      && !$past(present_out);
  endsequence
  property p_zero; s_absent |-> speed_out == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("speed not zero");
  property p_nohold; s_absent |-> !holding_out; endproperty
  a_nohold: assert property (p_nohold) else $error("hold");
  // an arrival clear lands on the edge where present_out rises, so skip that edge
  property p_nolen;
    s_absent ##0 !length_reset_in ##1 !present_out |-> $stable(length_out);
  endproperty
  a_nolen: assert property (p_nolen) else $error("length moved");
  property p_hold;
    present_out && $past(present_out) && $fell(speed_valid_in)
      |=> holding_out && $stable(speed_out);
  endproperty
  a_hold: assert property (p_hold) else $error("speed not held");
  property p_clear;
    clear_on_new_in && detect_mode_in && $rose(present_out)
      |-> ##[0:1] length_out == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("no clear");
  c_arrive: cover property ($rose(present_out));
  c_hold: cover property (holding_out);
  c_clear: cover property (clear_on_new_in && $rose(present_out));
endmodule // odsg_gate_asserts
`default_nettype wire

// ---- odsg_gate_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module odsg_gate_tb_top;
  logic mclk_in = 1'b0, sys_rst_in = 1'b1, detect_mode_in = 1'b1;
  logic clear_on_new_in = 1'b0, factory_restore_in = 1'b0;
  logic thresh_wr_in = 1'b0, speed_valid_in = 1'b1, len_tick_in = 1'b0;
  logic length_reset_in = 1'b0, present_out, holding_out;
  logic [6:0] thresh_data_in = 7'h00, dc_level_in = 7'h00, thresh_out;
  logic [15:0] speed_in = 16'h0005, speed_out;
  logic [31:0] hold_cycles_in = 32'h0000_0004, length_out, l0;
  int n_mismatch = 0, checks = 0;
  // free-running 100 MHz clock
  always #5 mclk_in = ~mclk_in;
  odsg_gate dut_u (.mclk_in, .sys_rst_in, .detect_mode_in, .clear_on_new_in,
    .factory_restore_in, .thresh_wr_in, .thresh_data_in, .dc_level_in,
    .speed_in, .speed_valid_in, .len_tick_in, .length_reset_in,
    .hold_cycles_in, .speed_out, .length_out, .present_out, .holding_out,
    .thresh_out);
  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // drive just after the edge so outputs have settled when compared
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // bounded wait; filter delay is far below the loop limit
  task automatic wait_pres(input logic v);
    for (int i = 0; i < 40; i++) begin
      if (present_out === v) return;
      step(1);
    end
    n_mismatch++;
    $display("[FAIL] %0t presence timeout", $time);
    conclude();
  endtask
  task automatic tick;
    len_tick_in <= 1'b1;
    step(1);
    len_tick_in <= 1'b0;
    step(1);
  endtask
  task automatic wr(input logic [6:0] d, input logic [6:0] exp);
    thresh_data_in <= d;
    thresh_wr_in <= 1'b1;
    step(1);
    thresh_wr_in <= 1'b0;
    step(1);
    cmp(thresh_out, exp);
  endtask
  task automatic t_thresh;
    cmp(thresh_out, 7'h0F);
    wr(7'h64, 7'h64);
    wr(7'h7F, 7'h64);
    wr(7'h00, 7'h00);
    factory_restore_in <= 1'b1;
    step(1);
    factory_restore_in <= 1'b0;
    step(1);
    cmp(thresh_out, 7'h0F);
  endtask
  task automatic t_presence;
    dc_level_in <= 7'h0F;
    step(30);
    cmp(present_out, 1'b0);
    cmp(speed_out, 16'h0000);
    tick();
    cmp(length_out, 32'h0000_0000);
    dc_level_in <= 7'h10;
    wait_pres(1'b1);
    step(2);
    cmp(speed_out, 16'h0005);
    tick();
    l0 = length_out;
    cmp(l0 != 32'h0000_0000, 1'b1);
    dc_level_in <= 7'h00;
    wait_pres(1'b0);
    step(2);
    cmp(speed_out, 16'h0000);
    tick();
    cmp(length_out, l0);
    dc_level_in <= 7'h10;
    wait_pres(1'b1);
    step(2);
    cmp(length_out, l0);
  endtask
  task automatic t_clear;
    clear_on_new_in <= 1'b1;
    dc_level_in <= 7'h00;
    wait_pres(1'b0);
    dc_level_in <= 7'h64;
    wait_pres(1'b1);
    step(2);
    cmp(length_out, 32'h0000_0000);
    clear_on_new_in <= 1'b0;
  endtask
  task automatic t_hold;
    tick();
    l0 = length_out;
    speed_valid_in <= 1'b0;
    step(2);
    cmp({holding_out, speed_out}, {1'b1, 16'h0005});
    tick();
    cmp(length_out > l0, 1'b1);
    step(8);
    cmp(speed_out, 16'h0000);
    l0 = length_out;
    tick();
    cmp(length_out, l0);
    speed_valid_in <= 1'b1;
    dc_level_in <= 7'h00;
    wait_pres(1'b0);
    speed_valid_in <= 1'b0;
    step(2);
    cmp(holding_out, 1'b0);
  endtask
  // external length reset, then detection mode off opens the gate
  task automatic t_misc;
    length_reset_in <= 1'b1;
    step(1);
    length_reset_in <= 1'b0;
    step(1);
    cmp(length_out, 32'h0000_0000);
    speed_valid_in <= 1'b1;
    detect_mode_in <= 1'b0;
    step(2);
    cmp(speed_out, 16'h0005);
    tick();
    cmp(length_out, 32'h0000_0001);
  endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    step(1);
    t_thresh();
    t_presence();
    t_clear();
    t_hold();
    t_misc();
    conclude();
  end
endmodule // odsg_gate_tb_top
bind odsg_gate odsg_gate_asserts chk_u (.mclk_in, .sys_rst_in,
  .detect_mode_in, .clear_on_new_in, .factory_restore_in, .dc_level_in,
  .speed_valid_in, .length_reset_in, .speed_out, .length_out, .present_out,
  .holding_out, .thresh_out);
`default_nettype wire
